/* File: common/limit_pkg.sv */
`default_nettype none
package limit_pkg;

    localparam int NUM_LIMITS = 8;
    localparam int NUM_ALERTS = 2;

    // ****************************************************************
    // command codes
    // ****************************************************************
    localparam logic [7:0] CMD_CAPABILITY   = 8'h19;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_PIN_OV      = 8'h42;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_PIN_UV      = 8'h43;
    localparam logic [7:0] CMD_IOUT_OC      = 8'h4a;
    localparam logic [7:0] CMD_OT_SHUTDOWN  = 8'h4f;
    localparam logic [7:0] CMD_OT_WARN      = 8'h51;
    localparam logic [7:0] CMD_VIN_OV       = 8'h57;
    localparam logic [7:0] CMD_VIN_UV       = 8'h58;
    localparam logic [7:0] CMD_PIN_OP       = 8'h6b;

    // ****************************************************************
    // capability fields
    // ****************************************************************
    localparam logic [7:0] CAP_RESET      = 8'hb0;
    localparam int         CAP_PEC_BIT    = 7;
    localparam int         CAP_SPEED_MSB  = 6;
    localparam int         CAP_SPEED_LSB  = 5;
    localparam logic [1:0] CAP_SPEED_400K = 2'h1;
    localparam int         CAP_ALERT_BIT  = 4;

    // ****************************************************************
    // threshold table, index order matches warn bits
    // ****************************************************************
    localparam logic [7:0] LIM_CMD [NUM_LIMITS] = '{
        CMD_OUTPUT_VOLTAGE_PIN_OV, CMD_OUTPUT_VOLTAGE_PIN_UV, CMD_IOUT_OC, CMD_OT_SHUTDOWN,
        CMD_OT_WARN, CMD_VIN_OV, CMD_VIN_UV, CMD_PIN_OP};
    localparam logic [15:0] LIM_RESET [NUM_LIMITS] = '{
        16'h0fff, 16'h0000, 16'h0fff, 16'h0fff,
        16'h0fff, 16'h0fff, 16'h0000, 16'h7fff};
    localparam logic [15:0] LIM_MASK [NUM_LIMITS] = '{
        16'h0fff, 16'h0fff, 16'h0fff, 16'h0fff,
        16'h0fff, 16'h0fff, 16'h0fff, 16'h7fff};
    // set bit means the flag is raised when the measurement falls below
    localparam logic [NUM_LIMITS-1:0] LIM_UNDER = 8'h42;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [14:0] pin;
        logic [11:0] temp;
        logic [11:0] iout;
        logic [11:0] vin;
        logic [11:0] output_voltage_pin;
    } meas_type;

    typedef struct packed {
        logic [7:0]  cmd;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } cmd_req_type;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } cmd_rsp_type;

    typedef enum logic [3:0] {
        ALERT_OFF,
        ALERT_OUTPUT_VOLTAGE_PIN_OV,
        ALERT_OUTPUT_VOLTAGE_PIN_UV,
        ALERT_IOUT_OC,
        ALERT_OT_SHUTDOWN,
        ALERT_OT_WARN,
        ALERT_VIN_OV,
        ALERT_VIN_UV,
        ALERT_PIN_OP
    } alert_src_type;

endpackage : limit_pkg
`default_nettype wire

/* File: design/monitor_limit_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module monitor_limit_register_bank (
    input  wire logic                                    mclk,
    input  wire logic                                    srst,
    input  wire limit_pkg::cmd_req_type                  req,
    input  wire logic                                    clear_faults,
    input  wire logic                                    conv_done,
    input  wire limit_pkg::meas_type                     meas,
    input  wire limit_pkg::alert_src_type [1:0]          alert_source_select,
    output limit_pkg::cmd_rsp_type                       rsp,
    output logic [limit_pkg::NUM_LIMITS-1:0]             warn_status,
    output logic [limit_pkg::NUM_ALERTS-1:0]             alert_pin_level
);
    import limit_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]            cap_r;
    logic [15:0]           lim_r    [NUM_LIMITS];
    logic [NUM_LIMITS-1:0] cmp_r;
    logic [NUM_LIMITS-1:0] cmp_nxt;
    logic [NUM_LIMITS-1:0] cmp_now;
    logic [NUM_LIMITS-1:0] status_r;
    logic [NUM_LIMITS-1:0] status_nxt;
    logic [NUM_LIMITS-1:0] lim_hit;
    logic [15:0]           meas_ext [NUM_LIMITS];
    logic [15:0]           lim_rdata;
    logic [15:0]           cap_rdata;
    logic                  cap_hit;
    logic                  any_lim_hit;
    logic                  bad_cmd;
    cmd_rsp_type           rsp_nxt;

    // ****************************************************************
    // measurement routing per threshold
    // ****************************************************************
    assign meas_ext[0] = {4'h0, meas.output_voltage_pin};
    assign meas_ext[1] = {4'h0, meas.output_voltage_pin};
    assign meas_ext[2] = {4'h0, meas.iout};
    assign meas_ext[3] = {4'h0, meas.temp};
    assign meas_ext[4] = {4'h0, meas.temp};
    assign meas_ext[5] = {4'h0, meas.vin};
    assign meas_ext[6] = {4'h0, meas.vin};
    assign meas_ext[7] = {1'b0, meas.pin};

    // ****************************************************************
    // threshold registers and comparators
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LIMITS; gi++) begin : g_lim
            assign lim_hit[gi] = (req.cmd == LIM_CMD[gi]);
            assign cmp_now[gi] = LIM_UNDER[gi] ? (meas_ext[gi] < lim_r[gi])
                                               : (meas_ext[gi] > lim_r[gi]);
            always_ff @(posedge mclk) begin
                if (srst) begin
                    lim_r[gi] <= LIM_RESET[gi];
                end else if (req.wr && !req.rd && lim_hit[gi]) begin
                    lim_r[gi] <= req.wdata & LIM_MASK[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // capability byte, never written
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            cap_r <= CAP_RESET;
        end else begin
            cap_r <= CAP_RESET;
        end
    end

    assign cap_rdata = {8'h00, cap_r[CAP_PEC_BIT],
                        CAP_SPEED_400K,
                        cap_r[CAP_ALERT_BIT],
                        4'h0};

    // ****************************************************************
    // command decode and read mux
    // ****************************************************************
    assign cap_hit     = (req.cmd == CMD_CAPABILITY);
    assign any_lim_hit = |lim_hit;

    always_comb begin
        lim_rdata = 16'h0000;
        for (int i = 0; i < NUM_LIMITS; i++) begin
            if (lim_hit[i]) begin
                lim_rdata = lim_rdata | (lim_r[i] & LIM_MASK[i]);
            end
        end
    end

    assign bad_cmd = (req.rd && req.wr) ||
                     (req.wr && !any_lim_hit) ||
                     (req.rd && !any_lim_hit && !cap_hit);

    always_comb begin
        rsp_nxt.ack   = req.rd || req.wr;
        rsp_nxt.err   = bad_cmd;
        rsp_nxt.rdata = 16'h0000;
        if (req.rd && !req.wr && cap_hit) begin
            rsp_nxt.rdata = cap_rdata;
        end else if (req.rd && !req.wr && any_lim_hit) begin
            rsp_nxt.rdata = lim_rdata;
        end
    end

    // ****************************************************************
    // comparison results and sticky warnings
    // ****************************************************************
    assign cmp_nxt    = conv_done ? cmp_now : cmp_r;
    assign status_nxt = (status_r & ~{NUM_LIMITS{clear_faults}}) |
                        (conv_done ? cmp_now : '0);

    always_ff @(posedge mclk) begin
        if (srst) begin
            cmp_r    <= '0;
            status_r <= '0;
            rsp      <= '0;
        end else begin
            cmp_r    <= cmp_nxt;
            status_r <= status_nxt;
            rsp      <= rsp_nxt;
        end
    end

    assign warn_status = status_r;

    // ****************************************************************
    // alert pins in comparator mode
    // ****************************************************************
    generate
        for (gi = 0; gi < NUM_ALERTS; gi++) begin : g_alert
            logic [3:0] src_idx;
            logic       lvl_nxt;
            assign src_idx = alert_source_select[gi] - 4'h1;
            assign lvl_nxt = (alert_source_select[gi] != ALERT_OFF) &&
                             (src_idx < 4'(NUM_LIMITS)) &&
                             cmp_nxt[src_idx[2:0]];
            always_ff @(posedge mclk) begin
                if (srst) begin
                    alert_pin_level[gi] <= 1'b0;
                end else begin
                    alert_pin_level[gi] <= lvl_nxt;
                end
            end
        end
    endgenerate

endmodule : monitor_limit_register_bank
`default_nettype wire

/* File: dv/limit_bank_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module limit_bank_asserts (
    input wire logic                           mclk,
    input wire logic                           srst,
    input wire limit_pkg::cmd_req_type         req,
    input wire logic                           clear_faults,
    input wire logic                           conv_done,
    input wire limit_pkg::meas_type            meas,
    input wire limit_pkg::alert_src_type [1:0] alert_source_select,
    input wire limit_pkg::cmd_rsp_type         rsp,
    input wire logic [7:0]                     warn_status,
    input wire logic [1:0]                     alert_pin_level
);
    import limit_pkg::*;
    wire logic req_any = req.rd || req.wr;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    ack_timing_a: assert property (rsp.ack == $past(req_any))
        else $error("ack not one cycle after request");
    cap_read_a: assert property (req.rd && !req.wr && req.cmd == CMD_CAPABILITY
        |=> rsp.rdata == 16'h00b0 && !rsp.err) else $error("capability read wrong");
    cap_write_a: assert property (req.wr && req.cmd == CMD_CAPABILITY
        |=> rsp.ack && rsp.err) else $error("capability write not refused");
    nibble_zero_a: assert property (req.rd && req.cmd != CMD_PIN_OP
        |=> rsp.rdata[15:12] == 4'h0) else $error("reserved nibble not zero");
    power_msb_a: assert property (req.rd && req.cmd == CMD_PIN_OP
        |=> !rsp.rdata[15]) else $error("power limit bit 15 not zero");
    clear_flags_a: assert property (clear_faults && !conv_done
        |=> warn_status == 8'h00) else $error("flags not cleared");
    sticky_flags_a: assert property (!clear_faults && !conv_done
        |=> $stable(warn_status)) else $error("flags changed without cause");
    flag_source_a: assert property (!conv_done
        |=> (warn_status & ~$past(warn_status)) == 8'h00) else $error("flag rose without conversion");
    alert_follow_a: assert property (conv_done && alert_source_select[0] == ALERT_OUTPUT_VOLTAGE_PIN_OV
        |=> !alert_pin_level[0] || warn_status[0]) else $error("alert level without flag");
endmodule : limit_bank_asserts
bind monitor_limit_register_bank limit_bank_asserts limit_bank_asserts_inst (.mclk, .srst, .req,
    .clear_faults, .conv_done, .meas, .alert_source_select, .rsp, .warn_status, .alert_pin_level);
`default_nettype wire

/* File: dv/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                   mclk,
    output var limit_pkg::cmd_req_type  req,
    input  wire limit_pkg::cmd_rsp_type rsp
);
    import limit_pkg::*;
    initial req = '0;
    task automatic xfer(input logic [7:0] c, input logic w, input logic r,
                        input logic [15:0] d, output cmd_rsp_type got);
        @(negedge mclk);
        req <= '{cmd: c, wr: w, rd: r, wdata: d};
        @(negedge mclk);
        // released cmd and wdata lines carry the inverse, never the last value; wr and rd go low
        req <= '{cmd: ~c, wr: 1'b0, rd: 1'b0, wdata: ~d};
        got = rsp;
    endtask : xfer
endmodule : host_model
`default_nettype wire

/* File: dv/monitor_limit_register_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module monitor_limit_register_bank_tb;
    import limit_pkg::*;
    logic                mclk = 1'b0;
    logic                srst = 1'b1;
    logic                clear_faults = 1'b0;
    logic                conv_done = 1'b0;
    meas_type            meas = '0;
    alert_src_type [1:0] alert_source_select = '{ALERT_VIN_UV, ALERT_OUTPUT_VOLTAGE_PIN_OV};
    cmd_req_type         req;
    cmd_rsp_type         rsp;
    cmd_rsp_type         got;
    logic [7:0]          warn_status;
    logic [1:0]          alert_pin_level;
    int                  err_count = 0;
    int                  samples_checked = 0;
    int                  cycles = 0;
    always #5 mclk = ~mclk;
    host_model host_model_inst (.mclk, .req, .rsp);
    monitor_limit_register_bank monitor_limit_register_bank_inst (.mclk, .srst, .req,
        .clear_faults, .conv_done, .meas, .alert_source_select, .rsp, .warn_status,
        .alert_pin_level);
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end
        else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic compare(input logic [17:0] g, input logic [17:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : compare
    task automatic access(input logic [7:0] c, input logic w, input logic [15:0] d,
                          input logic e, input logic [15:0] x);
        host_model_inst.xfer(c, w, !w, d, got);
        compare(got, {1'b1, e, x});
    endtask : access
    task automatic convert(input logic k, input meas_type m, input logic c,
                           input logic [7:0] w, input logic [1:0] a);
        @(negedge mclk);
        conv_done <= k;
        clear_faults <= c;
        meas <= m;
        @(negedge mclk);
        conv_done <= 1'b0;
        clear_faults <= 1'b0;
        meas <= ~meas;
        compare({8'h00, alert_pin_level, warn_status}, {8'h00, a, w});
    endtask : convert
    task automatic reset_values();
        access(CMD_CAPABILITY, 1'b0, 16'h0000, 1'b0, 16'h00b0);
        for (int i = 0; i < NUM_LIMITS; i++) begin
            access(LIM_CMD[i], 1'b0, 16'h0000, 1'b0, LIM_RESET[i]);
        end
    endtask : reset_values
    initial begin
        repeat (20) @(negedge mclk);
        srst <= 1'b0;
        reset_values();
        access(CMD_CAPABILITY, 1'b1, 16'hffff, 1'b1, 16'h0000);
        access(8'h00, 1'b0, 16'h0000, 1'b1, 16'h0000);
        access(CMD_PIN_OP, 1'b1, 16'hffff, 1'b0, 16'h0000);
        access(CMD_PIN_OP, 1'b0, 16'h0000, 1'b0, 16'h7fff);
        for (int i = 0; i < NUM_LIMITS; i++) begin
            access(LIM_CMD[i], 1'b1, (i == 7) ? 16'h8100 : 16'hf100, 1'b0, 16'h0000);
            access(LIM_CMD[i], 1'b0, 16'h0000, 1'b0, 16'h0100);
        end
        access(CMD_CAPABILITY, 1'b0, 16'h0000, 1'b0, 16'h00b0);
        convert(1'b1, {3'h0, {5{12'h101}}}, 1'b0, ~LIM_UNDER, 2'b01);
        convert(1'b1, {3'h0, {5{12'h0ff}}}, 1'b0, 8'hff, 2'b10);
        convert(1'b1, {3'h0, {5{12'h100}}}, 1'b1, 8'h00, 2'b00);
        convert(1'b1, {3'h0, {5{12'h101}}}, 1'b1, ~LIM_UNDER, 2'b01);
        convert(1'b0, {3'h0, {5{12'h000}}}, 1'b1, 8'h00, 2'b01);
        // distinct fields per measurement, other alert sources
        alert_source_select <= '{ALERT_OFF, ALERT_OT_SHUTDOWN};
        convert(1'b1, {15'h0100, 12'h101, 12'h100, 12'h0ff, 12'h100},
                1'b0, 8'h58, 2'b01);
        srst <= 1'b1;
        repeat (2) @(negedge mclk);
        srst <= 1'b0;
        compare({8'h00, alert_pin_level, warn_status}, 18'h0);
        reset_values();
        end_of_test();
    end
endmodule : monitor_limit_register_bank_tb
`default_nettype wire
